// [core/aiss_defs.vh]
// constants for the audio input source selector
`ifndef AISS_DEFS_VH
`define AISS_DEFS_VH
// apb register byte offsets
`define AISS_OFS_CTRL 12'h000
`define AISS_OFS_STATUS 12'h004
// control register fields
`define AISS_CTRL_SPDIF_SEL 0
`define AISS_CTRL_SPDIF_ANALOG 1
`define AISS_CTRL_SKIP 2
`define AISS_CTRL_SER_MASTER 3
`define AISS_CTRL_RATE_LO 4
`define AISS_CTRL_RATE_HI 5
`define AISS_CTRL_RESET 6'h00
// status register fields
`define AISS_STAT_SRC_LO 0
`define AISS_STAT_SRC_HI 1
`define AISS_STAT_SKIP 2
`define AISS_STAT_ROLE 3
`define AISS_STAT_CHAN_LO 4
`define AISS_STAT_CHAN_HI 6
`define AISS_STAT_OVF 7
// source codes
`define AISS_SRC_SER 2'h0
`define AISS_SRC_SPDIF 2'h1
`define AISS_SRC_AC97 2'h2
// link rate codes
`define AISS_RATE_48 2'h0
`define AISS_RATE_44K1 2'h1
`define AISS_RATE_88K2 2'h2
`define AISS_RATE_96 2'h3
// channel counts per configuration
`define AISS_CH_SER 3'h4
`define AISS_CH_SPDIF 3'h2
`define AISS_CH_AC97_48 3'h6
`define AISS_CH_AC97_44K1 3'h4
`define AISS_CH_AC97_DBL 3'h3
// slot request masks, bit n is link slot n+3
`define AISS_REQ_48 10'h07B
`define AISS_REQ_44K1 10'h033
`define AISS_REQ_DBL 10'h00B
`define AISS_REQ_NEXT 10'h380
// pacing of next samples at 88.2 kHz: 67/80 of frames
`define AISS_ACC_STEP 7'h43
`define AISS_ACC_MOD 7'h50
// link frame slot layout
`define AISS_LINK_SLOT0_BITS 16
`define AISS_LINK_SLOT_BITS 20
`define AISS_LINK_SLOTS 13
`define AISS_SER_SLOT_BITS 32
`define AISS_SER_SLOTS 4
`endif

// [core/aiss_fifo.v]
// sample frame fifo with registered output stage
`timescale 1ns/1ps
module aiss_fifo #(
  parameter WIDTH = 120,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // full only counts the array, the output stage is one extra word
  assign o_in_ready = (count_r != DEPTH[AW:0]);
  assign push = i_in_valid & o_in_ready;
  assign pop = (count_r != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);

  // storage array, no reset needed
  always @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers, level and output stage
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        o_out_data <= mem[rd_ptr_r];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // aiss_fifo

// [core/aiss_slot_rx.v]
// sampled-clock serial slot deserialiser for framed links
`timescale 1ns/1ps
module aiss_slot_rx #(
  parameter SLOT0_BITS = 16,
  parameter SLOT_BITS = 20,
  parameter NSLOTS = 13,
  parameter SAMPLE_FALL = 1
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_bclk,
  input wire i_sync,
  input wire i_sdata,
  output reg [31:0] o_word,
  output reg [3:0] o_slot,
  output reg o_word_stb,
  output reg o_frame_end
);
  reg [2:0] bclk_s;
  reg [1:0] sync_s;
  reg [1:0] data_s;
  reg sync_d_r;
  reg [5:0] bit_r;
  reg [3:0] slot_r;
  reg [31:0] shift_r;
  reg run_r;
  wire edge_smp;
  wire frame_go;
  wire [5:0] width;
  wire [31:0] shifted;

  // bclk_s[2] only compares against the second stage, never the first
  assign edge_smp = (SAMPLE_FALL != 0) ? (bclk_s[2] & ~bclk_s[1]) : (~bclk_s[2] & bclk_s[1]);
  assign frame_go = edge_smp & sync_s[1] & ~sync_d_r;
  assign width = (slot_r == 4'h0) ? SLOT0_BITS[5:0] : SLOT_BITS[5:0];
  assign shifted = {shift_r[30:0], data_s[1]};

  // two-stage synchronisers for pins on the link clock
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bclk_s <= 3'h0;
      sync_s <= 2'h0;
      data_s <= 2'h0;
    end else begin
      bclk_s <= {bclk_s[1:0], i_bclk};
      sync_s <= {sync_s[0], i_sync};
      data_s <= {data_s[0], i_sdata};
    end
  end

  // rising sync restarts the frame, bits are counted per slot
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync_d_r <= 1'b0;
      bit_r <= 6'h00;
      slot_r <= 4'h0;
      shift_r <= 32'h00000000;
      run_r <= 1'b0;
      o_word <= 32'h00000000;
      o_slot <= 4'h0;
      o_word_stb <= 1'b0;
      o_frame_end <= 1'b0;
    end else begin
      o_word_stb <= 1'b0;
      o_frame_end <= 1'b0;
      if (edge_smp) begin
        sync_d_r <= sync_s[1];
      end
      if (frame_go) begin
        run_r <= 1'b1;
        slot_r <= 4'h0;
        bit_r <= 6'h01;
        shift_r <= {31'h00000000, data_s[1]};
      end else if (edge_smp & run_r) begin
        shift_r <= shifted;
        if (bit_r == width - 6'h01) begin
          o_word <= shifted;
          o_slot <= slot_r;
          o_word_stb <= 1'b1;
          bit_r <= 6'h00;
          if (slot_r == NSLOTS[3:0] - 4'h1) begin
            // a frame without a fresh sync waits idle
            o_frame_end <= 1'b1;
            run_r <= 1'b0;
            slot_r <= 4'h0;
          end else begin
            slot_r <= slot_r + 4'h1;
          end
        end else begin
          bit_r <= bit_r + 6'h01;
        end
      end
    end
  end
endmodule // aiss_slot_rx

// [core/aiss_input_select.v]
// audio input stage: source selection, link slot mapping and resampler skip
`timescale 1ns/1ps
`include "aiss_defs.vh"

// What this block does
// R01: pin low, select bit one: S/PDIF
// R02: pin high selects the link always
// R03: S/PDIF two channels, resampler kept
// R04: input type bit picks analog or digital
// R05: role pin sets primary or secondary
// R06: link supports four sample rates
// R07: slot mapping for 48 and 44.1
// R08: double rate always requests slots 3,4,6
// R09: slots 10-12 requested only when needed
// R10: six-channel 48 kHz always skips resampler
// R11: serial master: four channels, skip bit
// R12: other link rates keep the resampler
// R13: exactly one source routed at once
// R14: pin low, select bit zero: serial
// R15: serial slave keeps the resampler
// R16: unsupplied channels carry zero samples
module aiss_input_select #(
  parameter SW = 20,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_source_select_pin,
  input wire i_link_role_pin,
  input wire i_link_bclk,
  input wire i_link_sync,
  input wire i_link_sdata,
  output reg [9:0] o_link_slot_req,
  input wire i_ser_bclk,
  input wire i_ser_lrck,
  input wire i_ser_sdata,
  input wire i_spdif_analog,
  input wire i_spdif_digital,
  output reg o_spdif_line,
  output reg o_spdif_analog_en,
  input wire i_spdif_valid,
  input wire [SW-1:0] i_spdif_left,
  input wire [SW-1:0] i_spdif_right,
  output reg [1:0] o_source,
  output reg o_resampler_skip,
  output reg [2:0] o_chan_count,
  output reg o_link_role,
  output wire o_frame_valid,
  input wire i_frame_ready,
  output wire [6*SW-1:0] o_frame_data
);
  localparam FW = 6 * SW;

  reg [5:0] ctrl_r;
  reg ovf_r;
  reg [1:0] src_nxt;
  reg skip_nxt;
  reg [2:0] chan_nxt;
  reg [1:0] pin_s;
  reg [1:0] role_s;
  reg [1:0] spa_s;
  reg [1:0] spd_s;
  reg role_seen_r;
  reg [SW-1:0] link_w [3:12];
  reg [12:0] tag_r;
  reg lk_end_r;
  reg [SW-1:0] ser_w [0:3];
  reg need_next_r;
  reg [6:0] acc_r;
  reg [6:0] acc_nxt;
  reg pend_v_r;
  reg [FW-1:0] pend_d_r;
  reg pend2_v_r;
  reg [FW-1:0] pend2_d_r;
  reg [FW-1:0] frame_a;
  reg [FW-1:0] frame_b;
  reg new_v;
  reg new2_v;
  reg [9:0] req_nxt;
  wire [1:0] rate;
  wire apb_acc;
  wire apb_hit;
  wire [31:0] status_w;
  wire [31:0] lk_word;
  wire [3:0] lk_slot;
  wire lk_stb;
  wire lk_end;
  wire [31:0] sr_word;
  wire [3:0] sr_slot;
  wire sr_stb;
  wire sr_end;
  wire fifo_in_ready;
  wire [SW-1:0] zs;
  wire [7:0] acc_sum;

  assign rate = ctrl_r[`AISS_CTRL_RATE_HI:`AISS_CTRL_RATE_LO];
  assign zs = {SW{1'b0}};
  // one spare bit, the pacing sum reaches past seven bits
  assign acc_sum = {1'b0, acc_r} + {1'b0, `AISS_ACC_STEP};
  assign apb_acc = i_psel & i_penable & o_pready;
  assign apb_hit = (i_paddr == `AISS_OFS_CTRL) | (i_paddr == `AISS_OFS_STATUS);
  assign status_w = {24'h000000, ovf_r, o_chan_count, o_link_role, o_resampler_skip, o_source};

  // external pins pass two flip-flops before use
  always @(posedge i_clk_sys) begin
    // strap stages run through reset so the capture after release sees the pin
    role_s <= {role_s[0], i_link_role_pin};
    if (i_sys_rst) begin
      pin_s <= 2'h0;
      spa_s <= 2'h0;
      spd_s <= 2'h0;
    end else begin
      pin_s <= {pin_s[0], i_source_select_pin};
      spa_s <= {spa_s[0], i_spdif_analog};
      spd_s <= {spd_s[0], i_spdif_digital};
    end
  end

  // R05 role strap
  // caught once after reset release, it is a board strap not a live control
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      role_seen_r <= 1'b0;
      o_link_role <= 1'b0;
    end else if (!role_seen_r) begin
      role_seen_r <= 1'b1;
      o_link_role <= role_s[1];
    end
  end

  // R13 one source only
  // source, resampler skip and channel count from pin, bits and rate
  always @* begin
    src_nxt = `AISS_SRC_SER;
    skip_nxt = 1'b0;
    chan_nxt = `AISS_CH_SER;
    if (pin_s[1]) begin
      // R02 link wins
      src_nxt = `AISS_SRC_AC97;
      case (rate)
        `AISS_RATE_48: begin
          // R10 forced skip
          skip_nxt = 1'b1;
          chan_nxt = `AISS_CH_AC97_48;
        end
        `AISS_RATE_44K1: begin
          // R12 resampler kept
          chan_nxt = `AISS_CH_AC97_44K1;
        end
        default: begin
          chan_nxt = `AISS_CH_AC97_DBL;
        end
      endcase
    end else if (ctrl_r[`AISS_CTRL_SPDIF_SEL]) begin
      // R01 biphase receiver
      src_nxt = `AISS_SRC_SPDIF;
      // R03 never skipped
      skip_nxt = 1'b0;
      chan_nxt = `AISS_CH_SPDIF;
    end else begin
      // R14 serial port
      src_nxt = `AISS_SRC_SER;
      // R11 master skip bit
      // R15 slave never skips
      skip_nxt = ctrl_r[`AISS_CTRL_SER_MASTER] & ctrl_r[`AISS_CTRL_SKIP];
      chan_nxt = `AISS_CH_SER;
    end
  end

  // R04 line type
  // registered mode outputs and the chosen biphase line
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_source <= `AISS_SRC_SER;
      o_resampler_skip <= 1'b0;
      o_chan_count <= `AISS_CH_SER;
      o_spdif_line <= 1'b0;
      o_spdif_analog_en <= 1'b0;
    end else begin
      o_source <= src_nxt;
      o_resampler_skip <= skip_nxt;
      o_chan_count <= chan_nxt;
      o_spdif_analog_en <= ctrl_r[`AISS_CTRL_SPDIF_ANALOG];
      o_spdif_line <= ctrl_r[`AISS_CTRL_SPDIF_ANALOG] ? spa_s[1] : spd_s[1];
    end
  end

  // apb slave: one wait state, then the access completes
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
      ctrl_r <= `AISS_CTRL_RESET;
    end else begin
      if (i_psel & i_penable & ~o_pready) begin
        o_pready <= 1'b1;
        o_pslverr <= ~apb_hit;
        if (i_pwrite | ~apb_hit) begin
          o_prdata <= 32'h00000000;
        end else if (i_paddr == `AISS_OFS_CTRL) begin
          o_prdata <= {26'h0000000, ctrl_r};
        end else begin
          o_prdata <= status_w;
        end
      end else begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
      end
      if (apb_acc & i_pwrite & (i_paddr == `AISS_OFS_CTRL)) begin
        ctrl_r <= i_pwdata[5:0];
      end
    end
  end

  // link frame receiver, codec samples on the falling bit clock edge
  aiss_slot_rx #(
    .SLOT0_BITS(`AISS_LINK_SLOT0_BITS),
    .SLOT_BITS(`AISS_LINK_SLOT_BITS),
    .NSLOTS(`AISS_LINK_SLOTS),
    .SAMPLE_FALL(1)
  ) u_link_rx (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_bclk(i_link_bclk),
    .i_sync(i_link_sync),
    .i_sdata(i_link_sdata),
    .o_word(lk_word),
    .o_slot(lk_slot),
    .o_word_stb(lk_stb),
    .o_frame_end(lk_end)
  );

  // serial port as four 32-bit slots per frame, msb-left samples
  aiss_slot_rx #(
    .SLOT0_BITS(`AISS_SER_SLOT_BITS),
    .SLOT_BITS(`AISS_SER_SLOT_BITS),
    .NSLOTS(`AISS_SER_SLOTS),
    .SAMPLE_FALL(0)
  ) u_ser_rx (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_bclk(i_ser_bclk),
    .i_sync(i_ser_lrck),
    .i_sdata(i_ser_sdata),
    .o_word(sr_word),
    .o_slot(sr_slot),
    .o_word_stb(sr_stb),
    .o_frame_end(sr_end)
  );

  // slot word capture; slot 0 tags mark which slots hold data
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tag_r <= 13'h0000;
      lk_end_r <= 1'b0;
    end else begin
      // frame end waits one edge so the slot 12 word has landed
      lk_end_r <= lk_end;
      if (lk_stb & (lk_slot == 4'h0)) begin
        tag_r <= {lk_word[3], lk_word[4], lk_word[5], lk_word[6], lk_word[7],
                  lk_word[8], lk_word[9], lk_word[10], lk_word[11], lk_word[12],
                  2'h0, lk_word[15]};
      end
    end
  end

  genvar gi;
  generate
    for (gi = 3; gi <= 12; gi = gi + 1) begin : g_slot
      // each link slot keeps its latest word
      always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          link_w[gi] <= {SW{1'b0}};
        end else if (lk_stb && (lk_slot == gi)) begin
          link_w[gi] <= lk_word[SW-1:0];
        end
      end
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ser
      // serial channels, top bits of each slot
      always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          ser_w[gi] <= {SW{1'b0}};
        end else if (sr_stb && (sr_slot == gi)) begin
          ser_w[gi] <= sr_word[31:32-SW];
        end
      end
    end
  endgenerate

  // R16 zero fill
  // frame order l, r, c, sl, sr, lfe from low bits; absent channels are zero
  always @* begin
    frame_a = {FW{1'b0}};
    frame_b = {FW{1'b0}};
    new_v = 1'b0;
    new2_v = 1'b0;
    case (o_source)
      `AISS_SRC_SPDIF: begin
        new_v = i_spdif_valid;
        frame_a = {zs, zs, zs, zs, i_spdif_right, i_spdif_left};
      end
      `AISS_SRC_AC97: begin
        new_v = lk_end_r & tag_r[0];
        case (rate)
          // R07 slot map
          `AISS_RATE_48: begin
            frame_a = {link_w[9], link_w[8], link_w[7], link_w[6], link_w[4], link_w[3]};
          end
          `AISS_RATE_44K1: begin
            frame_a = {zs, link_w[8], link_w[7], zs, link_w[4], link_w[3]};
          end
          default: begin
            // R09 next samples
            frame_a = {zs, zs, zs, link_w[6], link_w[4], link_w[3]};
            frame_b = {zs, zs, zs, link_w[12], link_w[11], link_w[10]};
            new2_v = need_next_r & tag_r[10] & tag_r[11] & tag_r[0];
          end
        endcase
      end
      default: begin
        new_v = sr_end;
        frame_a = {zs, ser_w[3], ser_w[2], zs, ser_w[1], ser_w[0]};
      end
    endcase
  end

  // R06 rate request
  // R08 fixed requests
  // R09 paced requests
  always @* begin
    acc_nxt = acc_r;
    case (rate)
      `AISS_RATE_48: req_nxt = `AISS_REQ_48;
      `AISS_RATE_44K1: req_nxt = `AISS_REQ_44K1;
      `AISS_RATE_96: req_nxt = `AISS_REQ_DBL | `AISS_REQ_NEXT;
      default: begin
        // 88.2 kHz needs a second sample in 67 of 80 frames
        acc_nxt = (acc_sum >= {1'b0, `AISS_ACC_MOD}) ?
                  acc_sum[6:0] - `AISS_ACC_MOD : acc_sum[6:0];
        req_nxt = (acc_sum >= {1'b0, `AISS_ACC_MOD}) ?
                  (`AISS_REQ_DBL | `AISS_REQ_NEXT) : `AISS_REQ_DBL;
      end
    endcase
  end

  // request for the coming frame, remembered to validate its slots 10-12
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      acc_r <= 7'h00;
      need_next_r <= 1'b0;
      o_link_slot_req <= `AISS_REQ_48;
    end else if (lk_end) begin
      acc_r <= acc_nxt;
      need_next_r <= o_link_slot_req[9];
      o_link_slot_req <= req_nxt;
    end
  end

  // two-deep issue stage feeding the fifo; a full fifo drops and flags
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pend_v_r <= 1'b0;
      pend_d_r <= {FW{1'b0}};
      pend2_v_r <= 1'b0;
      pend2_d_r <= {FW{1'b0}};
      ovf_r <= 1'b0;
    end else begin
      if (pend_v_r & fifo_in_ready) begin
        pend_v_r <= pend2_v_r;
        pend_d_r <= pend2_d_r;
        pend2_v_r <= 1'b0;
      end
      if (new_v & ~pend_v_r & ~pend2_v_r) begin
        pend_v_r <= 1'b1;
        pend_d_r <= frame_a;
        pend2_v_r <= new2_v;
        pend2_d_r <= frame_b;
      end
      // overflow set wins over a same-cycle clear
      if (new_v & (pend_v_r | pend2_v_r)) begin
        ovf_r <= 1'b1;
      end else if (apb_acc & i_pwrite & (i_paddr == `AISS_OFS_STATUS) & i_pwdata[`AISS_STAT_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  aiss_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(pend_v_r),
    .o_in_ready(fifo_in_ready),
    .i_in_data(pend_d_r),
    .o_out_valid(o_frame_valid),
    .i_out_ready(i_frame_ready),
    .o_out_data(o_frame_data)
  );
endmodule // aiss_input_select

// [tb/aiss_input_select_assertions.sv]
// concurrent checks on the audio input selector ports
`timescale 1ns/1ps
`include "aiss_defs.vh"
module aiss_input_select_assertions #(
  parameter SW = 20
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_source_select_pin,
  input wire [9:0] o_link_slot_req,
  input wire [1:0] o_source,
  input wire o_resampler_skip,
  input wire [2:0] o_chan_count,
  input wire o_link_role,
  input wire o_frame_valid,
  input wire [6*SW-1:0] o_frame_data
);
  reg [5:0] quiet_r;
  reg [5:0] ctrl_r;
  reg pin_r;
  reg [2:0] age_r;
  wire ctrl_wr;
  wire st;
  wire pin;
  wire [2:0] link_ch;
  assign pin = i_source_select_pin;
  assign ctrl_wr = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == `AISS_OFS_CTRL);
  assign st = quiet_r > 6'h03;
  assign link_ch = (ctrl_r[5:4] == `AISS_RATE_48) ? `AISS_CH_AC97_48 :
    (ctrl_r[5:4] == `AISS_RATE_44K1) ? `AISS_CH_AC97_44K1 : `AISS_CH_AC97_DBL;
  // settle count: mode outputs lag pin and control word by a few edges
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      quiet_r <= 6'h00;
      ctrl_r <= 6'h00;
      pin_r <= 1'b0;
      age_r <= 3'h0;
    end else begin
      pin_r <= pin;
      age_r <= age_r + {2'h0, age_r != 3'h7};
      if (ctrl_wr) ctrl_r <= i_pwdata[5:0];
      quiet_r <= (ctrl_wr || pin != pin_r) ? 6'h00 : quiet_r + {5'h00, quiet_r != 6'h3F};
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_link_source: assert property (st && pin |-> o_source == `AISS_SRC_AC97)
    else $error("link pin did not select the link");
  a_link_rate: assert property (st && pin |-> o_chan_count == link_ch &&
    o_resampler_skip == (ctrl_r[5:4] == `AISS_RATE_48)) else $error("link skip or channels");
  a_spdif_path: assert property (st && !pin && ctrl_r[0] |-> o_source == `AISS_SRC_SPDIF &&
    !o_resampler_skip && o_chan_count == `AISS_CH_SPDIF) else $error("spdif path wrong");
  a_serial_path: assert property (st && !pin && !ctrl_r[0] |-> o_source == `AISS_SRC_SER &&
    o_chan_count == `AISS_CH_SER && o_resampler_skip == (ctrl_r[3] & ctrl_r[2]))
    else $error("serial path wrong");
  a_one_source: assert property (o_source != 2'h3)
    else $error("no single source");
  a_apb_wait: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready) // bus timing
    else $error("wait state count wrong");
  a_err_unmapped: assert property (o_pslverr |-> o_pready && i_paddr != `AISS_OFS_CTRL && // bus error
    i_paddr != `AISS_OFS_STATUS) else $error("error on mapped address");
  a_role_fixed: assert property (age_r == 3'h7 |-> $stable(o_link_role))
    else $error("role changed after start");
  a_zero_unused: assert property (st && o_frame_valid && o_source == 2'h1
    |-> o_frame_data[6*SW-1:2*SW] == '0) else $error("unused channel not zero");
  a_next_whole: assert property (o_link_slot_req[9:7] == 3'h0 || o_link_slot_req[9:7] == 3'h7)
    else $error("next slots requested in part");
  c_spdif_word: cover property (o_frame_valid && o_source == `AISS_SRC_SPDIF);
  c_link_frame: cover property (o_frame_valid && o_source == `AISS_SRC_AC97);
  c_bus_error: cover property (o_pready && o_pslverr);
endmodule // aiss_input_select_assertions

// [tb/aiss_link_model.sv]
// behavioural link controller sending framed slots to the selector
`timescale 1ns/1ps
module aiss_link_model (
  input wire [9:0] i_slot_req,
  output logic o_bclk,
  output logic o_sync,
  output logic o_sdata
);
  logic [255:0] frame;
  initial begin
    o_bclk = 1'b0;
    o_sync = 1'b0;
    o_sdata = 1'b0;
  end
  // bit clock runs only inside frames and rests low between them
  task automatic send(input int frames);
    for (int f = 0; f < frames; f++) begin
      frame = '0;
      frame[255] = 1'b1;
      // slots 3-9 always, 10-12 on request
      for (int k = 3; k <= 12; k++) begin
        if (k < 10 || i_slot_req[k-3]) begin
          frame[255-k] = 1'b1;
          frame[259-20*k -: 20] = {k[3:0], 16'hC3A5};
        end
      end
      for (int b = 255; b >= 0; b--) begin
        o_bclk = 1'b1;
        o_sync = (b > 239);
        o_sdata = frame[b];
        #24;
        o_bclk = 1'b0;
        #24;
      end
      o_sync = 1'b0;
      // released line: inverse of last bit, never a stale value
      o_sdata = ~frame[0];
      #96;
    end
  endtask
endmodule // aiss_link_model

// [tb/tb_aiss_input_select.sv]
// self-checking bench for the audio input selector
`timescale 1ns/1ps
`include "aiss_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_aiss_input_select;
  localparam int SW = 20;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, err;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic i_source_select_pin = 1'b0, i_link_role_pin = 1'b1, i_frame_ready = 1'b1;
  logic i_spdif_analog = 1'b1, i_spdif_digital = 1'b0, i_spdif_valid = 1'b0;
  logic [SW-1:0] i_spdif_left = '0, i_spdif_right = '0;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, link_bclk, link_sync, link_sdata, o_spdif_line, o_spdif_analog_en;
  wire o_resampler_skip, o_link_role, o_frame_valid;
  wire [9:0] o_link_slot_req;
  wire [1:0] o_source;
  wire [2:0] o_chan_count;
  wire [6*SW-1:0] o_frame_data;
  int bad_count = 0, compares = 0, cycles = 0;
  logic [6*SW-1:0] q[$];
  logic [5:0] ctl_t[8] = '{6'h04, 6'h0C, 6'h08, 6'h05, 6'h01, 6'h10, 6'h20, 6'h34};
  logic [5:0] exp_t[8] = '{6'h20, 6'h24, 6'h20, 6'h11, 6'h36, 6'h22, 6'h1A, 6'h1A};
  logic [1:0] rate_t[4] = '{2'h1, 2'h0, 2'h3, 2'h2};
  always #2.5 i_clk_sys = ~i_clk_sys;
  aiss_input_select i_aiss_input_select (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_source_select_pin(i_source_select_pin), .i_link_role_pin(i_link_role_pin),
    .i_link_bclk(link_bclk), .i_link_sync(link_sync), .i_link_sdata(link_sdata),
    .o_link_slot_req(o_link_slot_req), .i_ser_bclk(1'b0), .i_ser_lrck(1'b0),
    .i_ser_sdata(1'b0), .i_spdif_analog(i_spdif_analog), .i_spdif_digital(i_spdif_digital),
    .o_spdif_line(o_spdif_line), .o_spdif_analog_en(o_spdif_analog_en),
    .i_spdif_valid(i_spdif_valid), .i_spdif_left(i_spdif_left), .i_spdif_right(i_spdif_right),
    .o_source(o_source), .o_resampler_skip(o_resampler_skip), .o_chan_count(o_chan_count),
    .o_link_role(o_link_role), .o_frame_valid(o_frame_valid), .i_frame_ready(i_frame_ready),
    .o_frame_data(o_frame_data));
  aiss_link_model i_aiss_link_model (.i_slot_req(o_link_slot_req), .o_bclk(link_bclk),
    .o_sync(link_sync), .o_sdata(link_sdata));
  function automatic logic [SW-1:0] sw(input int n);
    return {n[3:0], 16'hC3A5};
  endfunction
  task automatic finish_test();
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one bus transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    @(posedge i_clk_sys);
    while (o_pready !== 1'b1) @(posedge i_clk_sys);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic setm(input logic p, input logic [5:0] c);
    apb(1'b1, `AISS_OFS_CTRL, {26'h0, c});
    i_source_select_pin <= p;
    repeat (6) @(posedge i_clk_sys);
  endtask
  // frames leave the fifo only while the consumer is ready
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (o_frame_valid === 1'b1 && i_frame_ready) q.push_back(o_frame_data);
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    apb(1'b0, `AISS_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0) // ctrl reset
    apb(1'b1, `AISS_OFS_CTRL, 32'hFFFFFFFF);
    apb(1'b0, `AISS_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h3F) // ctrl width
    apb(1'b0, 12'h008, 32'h0);
    `CHK({err, rd}, 33'h100000000) // unmapped
    for (int i = 0; i < 8; i++) begin
      setm(i > 3, ctl_t[i]);
      apb(1'b0, `AISS_OFS_STATUS, 32'h0);
      `CHK(rd[6:0], {exp_t[i][5:3], 1'b1, exp_t[i][2:0]})
      `CHK({o_chan_count, o_resampler_skip, o_source}, exp_t[i])
    end
    setm(1'b0, 6'h03);
    `CHK({o_spdif_line, o_spdif_analog_en}, 2'b11)
    setm(1'b0, 6'h01);
    `CHK({o_spdif_line, o_spdif_analog_en}, 2'b00)
    // consumer stalls while twenty words arrive, then drains
    i_frame_ready <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge i_clk_sys);
      i_spdif_valid <= 1'b1;
      i_spdif_left <= 20'h10000 + i;
      i_spdif_right <= 20'h20000 + i;
      @(posedge i_clk_sys);
      i_spdif_valid <= 1'b0;
    end
    i_frame_ready <= 1'b1;
    repeat (40) @(posedge i_clk_sys);
    `CHK(q.size() > 16, 1'b1) // fifo depth
    `CHK(q[0], {80'h0, 20'h20000, 20'h10000})
    `CHK(q[16], {80'h0, 20'h20010, 20'h10010})
    for (int i = 0; i < 4; i++) begin
      setm(1'b1, {rate_t[i], 4'h0});
      i_aiss_link_model.send(2);
      q.delete();
      i_aiss_link_model.send(1);
      repeat (20) @(posedge i_clk_sys);
      case (rate_t[i])
        2'h0: `CHK(q[0], {sw(9), sw(8), sw(7), sw(6), sw(4), sw(3)})
        2'h1: `CHK(q[0], {20'h0, sw(8), sw(7), 20'h0, sw(4), sw(3)})
        default: `CHK(q[0], {60'h0, sw(6), sw(4), sw(3)})
      endcase
      if (rate_t[i] > 2'h1) `CHK({o_link_slot_req[3], o_link_slot_req[1:0]}, 3'h7)
      if (rate_t[i] == 2'h0) `CHK(o_link_slot_req, 10'h07B)
      if (rate_t[i] == 2'h3) `CHK(q[1], {60'h0, sw(12), sw(11), sw(10)})
    end
    finish_test();
  end
endmodule // tb_aiss_input_select
bind aiss_input_select aiss_input_select_assertions #(.SW(SW)) i_aiss_input_select_assertions (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_source_select_pin(i_source_select_pin),
  .o_link_slot_req(o_link_slot_req), .o_source(o_source), .o_resampler_skip(o_resampler_skip),
  .o_chan_count(o_chan_count), .o_link_role(o_link_role), .o_frame_valid(o_frame_valid),
  .o_frame_data(o_frame_data));
